// *** inc/key_guard_defines.svh ***
// Summary of operation
// - After power-up, once the first refresh delay (about 66 ms) has passed, all four access-key bytes are cleared to zero.
// - With the key-check enable setting at 255, guarded writes are accepted only after the correct 32-bit key is loaded.
// - Key protection covers the time, control, user RAM, configuration and user non-volatile registers.
// - All 32 loaded key bits are compared with the 32 stored key bits from the RAM mirror.
// - The key is built from bytes at 39h (bits 7:0), 3Ah (15:8), 3Bh (23:16) and 3Ch (31:24).
// - The key byte registers are write-only and always read back as zero.
// - The pointer register at 3Dh gives the byte address for direct non-volatile access.
// - The pointer register is always readable but its writes are key-guarded.
`ifndef KEY_GUARD_DEFINES_SVH
`define KEY_GUARD_DEFINES_SVH
`define KEY_BYTE0_ADDR     8'h39
`define KEY_BYTE1_ADDR     8'h3A
`define KEY_BYTE2_ADDR     8'h3B
`define KEY_BYTE3_ADDR     8'h3C
`define NV_PTR_ADDR        8'h3D
`define NV_PTR_RESET       8'hC0
`define KEY_BYTE_RESET     8'h00
`define KEY_ENABLE_VALUE   8'hFF
`define FIRST_REFRESH_MS   66
`define CLK_FREQ_KHZ       50000
`define FIRST_REFRESH_CYC  (`FIRST_REFRESH_MS * `CLK_FREQ_KHZ)
`endif

// *** inc/key_guard_pkg.sv ***
package key_guard_pkg;
  typedef enum logic [1:0] {
    ST_WAIT_REFRESH,
    ST_CLEAR_KEY,
    ST_RUN
  } guard_state_t;
endpackage

// *** hdl/key_cmp.sv ***
`timescale 1ns/100ps
// registered key compare; enable and match fold into one write permission
module key_cmp #(
  parameter int KEY_W = 32
) (
  input  wire logic             mclk_in,
  input  wire logic             resetn_in,
  input  wire logic [KEY_W-1:0] loaded_key_in,
  input  wire logic [KEY_W-1:0] stored_key_in,
  input  wire logic [7:0]       enable_setting_in,
  output logic                  write_ok_out
);
  `include "key_guard_defines.svh"
  logic write_ok_r;
  logic write_ok_nxt;

  // full-width compare; registered to keep the decode path short
  always_comb begin
    write_ok_nxt = (enable_setting_in != `KEY_ENABLE_VALUE) ||
                   (loaded_key_in == stored_key_in);
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      write_ok_r <= 1'b0;
    end else begin
      write_ok_r <= write_ok_nxt;
    end
  end

  assign write_ok_out = write_ok_r;

  property p_cmp_lock;
    @(posedge mclk_in) disable iff (!resetn_in)
      (enable_setting_in == `KEY_ENABLE_VALUE &&
       loaded_key_in != stored_key_in) |=> !write_ok_r;
  endproperty
  a_cmp_lock: assert property (p_cmp_lock)
    else $error("mismatching key left writes open");

  property p_cmp_open;
    @(posedge mclk_in) disable iff (!resetn_in)
      (enable_setting_in != `KEY_ENABLE_VALUE) |=> write_ok_r;
  endproperty
  a_cmp_open: assert property (p_cmp_open)
    else $error("writes locked with key check off");
endmodule

// *** hdl/key_guard.sv ***
`timescale 1ns/100ps
`include "key_guard_defines.svh"
module key_guard
  import key_guard_pkg::*;
#(
  parameter int REFRESH_CYCLES = `FIRST_REFRESH_CYC
) (
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  input  wire logic [7:0]  key_check_enable_setting_in,
  input  wire logic [31:0] stored_key_bytes_in,
  input  wire logic        guarded_target_in,
  output logic             guarded_wr_out,
  output logic      [7:0]  nonvolatile_byte_pointer_field_out,
  output logic             write_unlocked_out
);
  // refresh default needs the macros before the header, so included above
  guard_state_t state_r;
  guard_state_t state_nxt;
  logic [31:0]  delay_r;
  logic [31:0]  delay_nxt;
  logic [7:0]   key_r [4];
  logic [7:0]   key_nxt [4];
  logic [31:0]  access_key;
  logic [7:0]   ptr_r;
  logic [7:0]   ptr_nxt;
  logic [7:0]   rdata_r;
  logic [7:0]   rdata_nxt;
  logic         gwr_r;
  logic         gwr_nxt;
  logic         write_ok;
  logic         key_hit;
  logic [1:0]   key_idx;

  assign access_key = {key_r[3], key_r[2], key_r[1], key_r[0]};

  key_cmp #(
    .KEY_W(32)
  ) u_cmp (
    .mclk_in          (mclk_in),
    .resetn_in        (resetn_in),
    .loaded_key_in    (access_key),
    .stored_key_in    (stored_key_bytes_in),
    .enable_setting_in(key_check_enable_setting_in),
    .write_ok_out     (write_ok)
  );

  // key byte decode; the four offsets are contiguous
  always_comb begin
    key_hit = (addr_in >= `KEY_BYTE0_ADDR) && (addr_in <= `KEY_BYTE3_ADDR);
    key_idx = 2'(addr_in - `KEY_BYTE0_ADDR);
  end

  // power-up sequencer: keys wiped once refresh delay has elapsed
  always_comb begin
    state_nxt = state_r;
    delay_nxt = delay_r;
    case (state_r)
      ST_WAIT_REFRESH: begin
        if (delay_r >= 32'(REFRESH_CYCLES - 1)) begin
          state_nxt = ST_CLEAR_KEY;
        end else begin
          delay_nxt = delay_r + 32'h0000_0001;
        end
      end
      ST_CLEAR_KEY: state_nxt = ST_RUN;
      ST_RUN:       state_nxt = ST_RUN;
      default:      state_nxt = ST_WAIT_REFRESH;
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= ST_WAIT_REFRESH;
      delay_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      delay_r <= delay_nxt;
    end
  end

  // key bytes: writes always land, the clear step overrides them
  // a write in the clear cycle is lost; software should wait for unlock
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      key_nxt[i] = key_r[i];
    end
    if (state_r == ST_CLEAR_KEY) begin
      for (int i = 0; i < 4; i++) begin
        key_nxt[i] = `KEY_BYTE_RESET;
      end
    end else if (wr_in && key_hit) begin
      key_nxt[key_idx] = wdata_in;
    end
  end

  generate
    for (genvar g = 0; g < 4; g++) begin : g_key
      always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          key_r[g] <= `KEY_BYTE_RESET;
        end else begin
          key_r[g] <= key_nxt[g];
        end
      end
    end
  endgenerate

  // pointer and guarded strobe; the key bytes themselves are never guarded
  always_comb begin
    ptr_nxt = ptr_r;
    gwr_nxt = 1'b0;
    if (wr_in && write_ok) begin
      if (addr_in == `NV_PTR_ADDR) begin
        ptr_nxt = wdata_in;
      end
      gwr_nxt = guarded_target_in;
    end
  end

  // read path: key bytes read zero, pointer always readable
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_in) begin
      if (key_hit) begin
        rdata_nxt = 8'h00;
      end else if (addr_in == `NV_PTR_ADDR) begin
        rdata_nxt = ptr_r;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ptr_r   <= `NV_PTR_RESET;
      gwr_r   <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ptr_r   <= ptr_nxt;
      gwr_r   <= gwr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_out                         = rdata_r;
  assign guarded_wr_out                    = gwr_r;
  assign nonvolatile_byte_pointer_field_out = ptr_r;
  assign write_unlocked_out                = write_ok;

  property p_key_reads_zero;
    @(posedge mclk_in) disable iff (!resetn_in)
      (rd_in && key_hit) |=> (rdata_out == 8'h00);
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero)
    else $error("key byte read not zero");

  property p_clear_keys;
    @(posedge mclk_in) disable iff (!resetn_in)
      (state_r == ST_CLEAR_KEY) |=> (access_key == 32'h0000_0000);
  endproperty
  a_clear_keys: assert property (p_clear_keys)
    else $error("keys not cleared after refresh delay");

  property p_locked_ptr;
    @(posedge mclk_in) disable iff (!resetn_in)
      (wr_in && !write_ok && addr_in == `NV_PTR_ADDR)
        |=> $stable(ptr_r);
  endproperty
  a_locked_ptr: assert property (p_locked_ptr)
    else $error("locked pointer write changed pointer");

  property p_unlocked_ptr;
    @(posedge mclk_in) disable iff (!resetn_in)
      (wr_in && write_ok && addr_in == `NV_PTR_ADDR)
        |=> (ptr_r == $past(wdata_in));
  endproperty
  a_unlocked_ptr: assert property (p_unlocked_ptr)
    else $error("unlocked pointer write lost");

  property p_ptr_read;
    @(posedge mclk_in) disable iff (!resetn_in)
      (rd_in && addr_in == `NV_PTR_ADDR) |=> (rdata_out == $past(ptr_r));
  endproperty
  a_ptr_read: assert property (p_ptr_read)
    else $error("pointer read wrong");

  property p_guard_strobe;
    @(posedge mclk_in) disable iff (!resetn_in)
      guarded_wr_out |-> $past(write_ok) && $past(wr_in);
  endproperty
  a_guard_strobe: assert property (p_guard_strobe)
    else $error("guarded strobe without permission");

  property p_key_assembly;
    @(posedge mclk_in) disable iff (!resetn_in)
      (wr_in && addr_in == `KEY_BYTE3_ADDR && state_r == ST_RUN)
        |=> (access_key[31:24] == $past(wdata_in));
  endproperty
  a_key_assembly: assert property (p_key_assembly)
    else $error("key byte three misplaced");

  property p_enabled_lock;
    @(posedge mclk_in) disable iff (!resetn_in)
      (key_check_enable_setting_in == `KEY_ENABLE_VALUE &&
       access_key != stored_key_bytes_in) ##1
      (key_check_enable_setting_in == `KEY_ENABLE_VALUE &&
       wr_in) |=> !guarded_wr_out;
  endproperty
  a_enabled_lock: assert property (p_enabled_lock)
    else $error("guarded write taken with wrong key");

  // sequencer: no early wipe, exactly one clear cycle, then run for good
  property p_wait_no_clear;
    @(posedge mclk_in) disable iff (!resetn_in)
      (state_r == ST_WAIT_REFRESH && delay_r < 32'(REFRESH_CYCLES - 1))
        |=> (state_r == ST_WAIT_REFRESH);
  endproperty
  a_wait_no_clear: assert property (p_wait_no_clear)
    else $error("key wipe before refresh delay");

  property p_wait_to_clear;
    @(posedge mclk_in) disable iff (!resetn_in)
      (state_r == ST_WAIT_REFRESH && delay_r >= 32'(REFRESH_CYCLES - 1))
        |=> (state_r == ST_CLEAR_KEY);
  endproperty
  a_wait_to_clear: assert property (p_wait_to_clear)
    else $error("key wipe missed after refresh delay");

  property p_clear_once;
    @(posedge mclk_in) disable iff (!resetn_in)
      (state_r == ST_CLEAR_KEY) |=> (state_r == ST_RUN);
  endproperty
  a_clear_once: assert property (p_clear_once)
    else $error("clear step lasted more than one cycle");

  property p_run_holds;
    @(posedge mclk_in) disable iff (!resetn_in)
      (state_r == ST_RUN) |=> (state_r == ST_RUN);
  endproperty
  a_run_holds: assert property (p_run_holds)
    else $error("sequencer left run state");

  // key writes land in the byte picked by the offset, guarded or not
  property p_key_write_lands;
    @(posedge mclk_in) disable iff (!resetn_in)
      (wr_in && key_hit && state_r != ST_CLEAR_KEY)
        |=> (key_r[$past(key_idx)] == $past(wdata_in));
  endproperty
  a_key_write_lands: assert property (p_key_write_lands)
    else $error("key byte write lost");

  property p_key_byte0;
    @(posedge mclk_in) disable iff (!resetn_in)
      (wr_in && addr_in == `KEY_BYTE0_ADDR && state_r != ST_CLEAR_KEY)
        |=> (access_key[7:0] == $past(wdata_in));
  endproperty
  a_key_byte0: assert property (p_key_byte0)
    else $error("key byte zero misplaced");

  property p_key_byte1;
    @(posedge mclk_in) disable iff (!resetn_in)
      (wr_in && addr_in == `KEY_BYTE1_ADDR && state_r != ST_CLEAR_KEY)
        |=> (access_key[15:8] == $past(wdata_in));
  endproperty
  a_key_byte1: assert property (p_key_byte1)
    else $error("key byte one misplaced");

  property p_key_byte2;
    @(posedge mclk_in) disable iff (!resetn_in)
      (wr_in && addr_in == `KEY_BYTE2_ADDR && state_r != ST_CLEAR_KEY)
        |=> (access_key[23:16] == $past(wdata_in));
  endproperty
  a_key_byte2: assert property (p_key_byte2)
    else $error("key byte two misplaced");

  // pointer moves only on its own write; a stray change would misaddress
  property p_ptr_idle;
    @(posedge mclk_in) disable iff (!resetn_in)
      !(wr_in && addr_in == `NV_PTR_ADDR) |=> $stable(ptr_r);
  endproperty
  a_ptr_idle: assert property (p_ptr_idle)
    else $error("pointer changed without a write");

  property p_locked_no_strobe;
    @(posedge mclk_in) disable iff (!resetn_in)
      (wr_in && !write_ok) |=> !guarded_wr_out;
  endproperty
  a_locked_no_strobe: assert property (p_locked_no_strobe)
    else $error("guarded strobe while locked");

  property p_unlocked_strobe;
    @(posedge mclk_in) disable iff (!resetn_in)
      (wr_in && write_ok && guarded_target_in)
        |=> guarded_wr_out;
  endproperty
  a_unlocked_strobe: assert property (p_unlocked_strobe)
    else $error("permitted guarded write dropped");

  // read data are zero outside the cycle after a read strobe
  property p_idle_rdata;
    @(posedge mclk_in) disable iff (!resetn_in)
      !rd_in |=> (rdata_out == 8'h00);
  endproperty
  a_idle_rdata: assert property (p_idle_rdata)
    else $error("read data without a read");

  property p_unmapped_read;
    @(posedge mclk_in) disable iff (!resetn_in)
      (rd_in && !key_hit && addr_in != `NV_PTR_ADDR)
        |=> (rdata_out == 8'h00);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");
endmodule

// *** dv/key_guard_bench.sv ***
`timescale 1ns/100ps
`include "key_guard_defines.svh"
module key_guard_bench;
  import key_guard_pkg::*;
  localparam int REFRESH = 40; // short first-refresh delay for simulation
  logic        mclk_in, resetn_in, wr_in, rd_in, tgt_in;
  logic [7:0]  addr_in, wdata_in, rdata_out, en_in, ptr_out, p, d;
  logic [31:0] stored_in, loaded, bad;
  logic        gwr_out, unl_out;
  int          bad_count, n_tests;

  key_guard #(.REFRESH_CYCLES(REFRESH)) DUT (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .key_check_enable_setting_in(en_in),
    .stored_key_bytes_in(stored_in), .guarded_target_in(tgt_in),
    .guarded_wr_out(gwr_out), .nonvolatile_byte_pointer_field_out(ptr_out),
    .write_unlocked_out(unl_out));

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  // writes are unlocked unless the check is on and the keys differ
  function automatic logic exp_unl(logic [7:0] en, logic [31:0] k, s);
    return (en != `KEY_ENABLE_VALUE) || (k == s);
  endfunction

  task automatic chk8(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask

  // one-cycle write; the bench mirrors what it puts in the key bytes
  task automatic wr(input logic [7:0] a, dd, input logic g);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= dd;
    tgt_in <= g;
    wr_in <= 1'b1;
    if (a >= `KEY_BYTE0_ADDR && a <= `KEY_BYTE3_ADDR)
      loaded[8*(a-`KEY_BYTE0_ADDR) +: 8] = dd;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    tgt_in <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 q = rdata_out;
  endtask

  // unlock follows a key write two cycles later; allow two spare
  task automatic unl_check;
    repeat (3) @(posedge mclk_in);
    #1 chk1("write_unlocked", exp_unl(en_in, loaded, stored_in),
            unl_out);
  endtask

  task automatic load_key(input logic [31:0] k);
    for (int i = 0; i < 4; i++) wr(`KEY_BYTE0_ADDR + 8'(i), k[8*i +: 8], 0);
  endtask

  task automatic gw_check(input logic e);
    wr(8'h10, 8'($urandom), 1'b1);
    #1 chk1("guarded_wr", e, gwr_out);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    {resetn_in, wr_in, rd_in, tgt_in, addr_in, wdata_in} = '0;
    en_in = `KEY_ENABLE_VALUE;
    loaded = 32'h0000_0000;
    bad_count = 0;
    n_tests = 0;
    void'($urandom(8880));
    stored_in = $urandom;
    repeat (6) @(posedge mclk_in);
    resetn_in <= 1'b1;
    #1 chk8("pointer_reset", `NV_PTR_RESET, ptr_out);
    // key loaded before the first refresh is wiped when it expires
    load_key(stored_in);
    unl_check();
    repeat (REFRESH + 20) @(posedge mclk_in);
    loaded = 32'h0000_0000;
    unl_check();
    p = $urandom;
    wr(`NV_PTR_ADDR, p, 1'b0);
    rd(`NV_PTR_ADDR, d);
    chk8("pointer_locked", `NV_PTR_RESET, d);
    gw_check(1'b0);
    load_key(stored_in);
    unl_check();
    for (int i = 0; i < 4; i++) begin
      rd(`KEY_BYTE0_ADDR + 8'(i), d);
      chk8("key_byte_read", 8'h00, d);
    end
    wr(`NV_PTR_ADDR, p, 1'b0);
    #1 chk8("pointer_field", p, ptr_out);
    rd(`NV_PTR_ADDR, d);
    chk8("pointer_read", p, d);
    gw_check(1'b1);
    // one flipped bit in each key byte must lock guarded writes
    for (int i = 0; i < 4; i++) begin
      bad = stored_in ^ (32'h1 << (8*i + $urandom_range(7, 0)));
      wr(`KEY_BYTE0_ADDR + 8'(i), bad[8*i +: 8], 1'b0);
      unl_check();
      gw_check(1'b0);
      wr(`NV_PTR_ADDR, ~p, 1'b0);
      rd(`NV_PTR_ADDR, d);
      chk8("pointer_kept", p, d);
      // setting changes ride the clock edge like every other input
      @(posedge mclk_in);
      en_in <= 8'($urandom_range(254, 0));
      unl_check();
      gw_check(1'b1);
      @(posedge mclk_in);
      en_in <= `KEY_ENABLE_VALUE;
      load_key(stored_in);
      unl_check();
    end
    rd(8'h50, d);
    chk8("unmapped_read", 8'h00, d);
    // a mid-run reset restores the pointer and locks writes again
    @(posedge mclk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    resetn_in <= 1'b1;
    loaded = 32'h0000_0000;
    #1 chk8("pointer_reset_again", `NV_PTR_RESET, ptr_out);
    chk1("unlocked_in_reset", 1'b0, unl_out);
    unl_check();
    give_verdict();
  end
endmodule
